// ---- design/osw_pkg.sv ----
// Package for the octal switch serial control link: widths, reset values, timing counts.
// Assumes a single 25 MHz system clock shared by both ends.
package osw_pkg;
  localparam int           OSW_W           = 8;
  localparam logic [7:0]   OSW_ALL_OFF     = 8'hff;
  localparam logic [2:0]   OSW_MSB         = 3'h7;
  localparam logic [2:0]   OSW_ZERO3       = 3'h0;
  localparam int           OSW_CLK_MHZ     = 25;
  localparam int           OSW_SF_DLY_US   = 150;
  localparam int           OSW_SF_DLY_CYC  = OSW_SF_DLY_US * OSW_CLK_MHZ;
  localparam int           OSW_SCK_HALF_NS = 200;
  localparam int           OSW_SCK_HALF    = (OSW_SCK_HALF_NS * OSW_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]   OSW_DIV_LAST    = 4'(OSW_SCK_HALF - 1);
  localparam logic [2:0]   OSW_CHAIN_MAX   = 3'h4;
  localparam logic [11:0]  OSW_SF_LAST     = 12'hea5;
  typedef enum logic [2:0] {
    OSW_IDLE  = 3'b000,
    OSW_LEAD  = 3'b001,
    OSW_HIGH  = 3'b010,
    OSW_LOW   = 3'b011,
    OSW_LAG   = 3'b100
  } osw_mstate_t;
endpackage

// ---- design/osw_if.sv ----
// Interface joining the switch device end and the microcontroller end.
// Assumes the host reads the serial output wire directly; its enable only feeds the checker.
`timescale 1ns/10ps
interface osw_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso, input miso_oe);
endinterface

// ---- design/osw_dev.sv ----
// Device end: serial shift register, command latches, short-fault latch-off.
// Assumes link pins are asynchronous to CLK and are synchronised here.
//
// Contract
// - Eight-bit command, one bit per output
// - Zero bit ON, one bit OFF
// - One bit in, one bit out per clock
// - Shift out drain status while receiving
// - Daisy chain: eight bits per device
// - Parallel devices use separate chip selects
// - Shorted ON output latched off after delay
// - Fault while deselected shows in next status
// - Chip select rise loads command latches
// - Sample falling edge, update output rising
// - MSB first, bit 7 is output 7
// - Reset sets shift register to all ones, all outputs OFF
`timescale 1ns/10ps
module osw_dev
  import osw_pkg::*;
#(
  parameter int SF_DLY_CYC = OSW_SF_DLY_CYC
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  osw_if.dev                    LINK,
  input  wire logic             SHORT_FAULT_LATCH_DISABLE,
  input  wire logic [OSW_W-1:0] SHORT_FAULT,
  input  wire logic [OSW_W-1:0] OPEN_FAULT,
  output logic      [OSW_W-1:0] OUT_OFF
);
  logic [2:0]       cs_s_q;
  logic [2:0]       sck_s_q;
  logic [1:0]       si_s_q;
  logic [1:0]       sfd_s_q;
  logic [OSW_W-1:0] sf_a_q;
  logic [OSW_W-1:0] sf_b_q;
  logic [OSW_W-1:0] of_a_q;
  logic [OSW_W-1:0] of_b_q;
  logic [OSW_W-1:0] sh_q;
  logic [OSW_W-1:0] cmd_q;
  logic [OSW_W-1:0] dis_q;
  logic [31:0]      sf_cnt_q;
  logic             so_q;
  logic             oe_q;
  logic             cs_n;
  logic             cs_rise;
  logic             cs_fall;
  logic             sck_rise;
  logic             sck_fall;
  logic [OSW_W-1:0] drain_hi;

  // Only stages 1 and 2 are read; stage 0 is the raw capture flop
  assign cs_n     = cs_s_q[1];
  assign cs_rise  = cs_s_q[1] & ~cs_s_q[2];
  assign cs_fall  = ~cs_s_q[1] & cs_s_q[2];
  assign sck_rise = sck_s_q[1] & ~sck_s_q[2] & ~cs_n;
  assign sck_fall = ~sck_s_q[1] & sck_s_q[2] & ~cs_n;
  // Drain high when OFF or latched off; an open load pulls an OFF drain low
  assign drain_hi = (cmd_q & ~of_b_q) | dis_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 2'h0;
      sfd_s_q <= 2'h0;
      sf_a_q  <= 8'h00;
      sf_b_q  <= 8'h00;
      of_a_q  <= 8'h00;
      of_b_q  <= 8'h00;
    end else begin
      sf_a_q  <= SHORT_FAULT;
      sf_b_q  <= sf_a_q;
      of_a_q  <= OPEN_FAULT;
      of_b_q  <= of_a_q;
      cs_s_q  <= {cs_s_q[1:0], LINK.cs_n};
      sck_s_q <= {sck_s_q[1:0], LINK.sclk};
      si_s_q  <= {si_s_q[0], LINK.mosi};
      sfd_s_q <= {sfd_s_q[0], SHORT_FAULT_LATCH_DISABLE};
    end
  end

  // Status loads on select; input bit enters on falling edge, MSB leaves first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_q <= OSW_ALL_OFF;
    end else if (cs_fall) begin
      sh_q <= drain_hi;
    end else if (sck_fall) begin
      sh_q <= {sh_q[OSW_W-2:0], si_s_q[1]};
    end
  end

  // Output bit is held between rising edges, which lets a chain pass bits on
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      so_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~cs_n;
      if (cs_fall) begin
        so_q <= drain_hi[OSW_MSB];
      end else if (sck_rise) begin
        so_q <= sh_q[OSW_MSB];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q <= OSW_ALL_OFF;
    end else if (cs_rise) begin
      cmd_q <= sh_q;
    end
  end

  // Latch-off waits the report delay after select rises; new command re-arms
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sf_cnt_q <= 32'h0;
      dis_q    <= 8'h00;
    end else if (cs_rise) begin
      sf_cnt_q <= 32'(SF_DLY_CYC);
      dis_q    <= 8'h00;
    end else if (sf_cnt_q != 32'h0) begin
      sf_cnt_q <= sf_cnt_q - 32'h1;
    end else if (!sfd_s_q[1]) begin
      dis_q <= dis_q | (~cmd_q & sf_b_q);
    end
  end

  assign LINK.miso    = so_q;
  assign LINK.miso_oe = oe_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_OFF <= OSW_ALL_OFF;
    end else begin
      OUT_OFF <= cmd_q | dis_q;
    end
  end
endmodule

// ---- design/osw_host.sv ----
// Microcontroller end: SPI master that shifts one or more 8-bit words per frame.
// Assumes the device end shares CLK; a two-entry buffer holds answer words only.
`timescale 1ns/10ps
module osw_host
  import osw_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  osw_if.host                   LINK,
  input  wire logic [2:0]       CHAIN_LEN,
  input  wire logic             TX_VALID,
  input  wire logic [OSW_W-1:0] TX_DATA,
  output logic                  TX_READY,
  output logic                  RX_VALID,
  output logic      [OSW_W-1:0] RX_DATA,
  input  wire logic             RX_READY,
  output logic                  BUSY
);
  osw_mstate_t      st_q;
  logic [3:0]       div_q;
  logic [2:0]       bit_q;
  logic [2:0]       word_q;
  logic [OSW_W-1:0] tx_q;
  logic [OSW_W-1:0] rx_q;
  logic [1:0]       mi_s_q;
  logic [OSW_W-1:0] buf_q [2];
  logic [1:0]       cnt_q;
  logic             wp_q;
  logic             rp_q;
  logic             tick;
  logic             word_done;
  logic             rx_push;
  logic             rx_full;
  logic             tx_take;
  logic             cs_q;
  logic             sck_q;

  assign tick      = (div_q == OSW_DIV_LAST);
  assign rx_full   = (cnt_q == 2'h2);
  assign word_done = tick && st_q == OSW_LOW && bit_q == OSW_ZERO3;
  assign rx_push   = word_done;
  assign tx_take   = TX_VALID && TX_READY;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q  <= 4'h0;
      mi_s_q <= 2'h0;
    end else begin
      div_q  <= tick ? 4'h0 : div_q + 4'h1;
      mi_s_q <= {mi_s_q[0], LINK.miso};
    end
  end

  // Frames start only with the answer buffer empty; clock idles low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q   <= OSW_IDLE;
      cs_q   <= 1'b1;
      sck_q  <= 1'b0;
      bit_q  <= OSW_MSB;
      word_q <= OSW_ZERO3;
      tx_q   <= OSW_ALL_OFF;
      rx_q   <= 8'h00;
    end else if (tick) begin
      unique case (st_q)
        OSW_IDLE: if (tx_take) begin
          tx_q  <= TX_DATA;
          cs_q  <= 1'b0;
          st_q  <= OSW_LEAD;
        end
        OSW_LEAD: begin
          sck_q <= 1'b1;
          st_q  <= OSW_HIGH;
        end
        OSW_HIGH: begin
          sck_q <= 1'b0;
          rx_q  <= {rx_q[OSW_W-2:0], mi_s_q[1]};
          st_q  <= OSW_LOW;
        end
        OSW_LOW: begin
          if (bit_q != OSW_ZERO3) begin
            tx_q  <= {tx_q[OSW_W-2:0], 1'b1};
            bit_q <= bit_q - 3'h1;
            sck_q <= 1'b1;
            st_q  <= OSW_HIGH;
          end else if (word_q + 3'h1 < CHAIN_LEN && tx_take) begin
            tx_q   <= TX_DATA;
            bit_q  <= OSW_MSB;
            word_q <= word_q + 3'h1;
            sck_q  <= 1'b1;
            st_q   <= OSW_HIGH;
          end else if (word_q + 3'h1 >= CHAIN_LEN) begin
            st_q <= OSW_LAG;
          end
        end
        OSW_LAG: begin
          cs_q   <= 1'b1;
          bit_q  <= OSW_MSB;
          word_q <= OSW_ZERO3;
          st_q   <= OSW_IDLE;
        end
        default: st_q <= OSW_IDLE;
      endcase
    end
  end

  // Two-entry answer buffer; a stalled reader holds off the next word
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 2'h0;
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
    end else begin
      if (rx_push) begin
        buf_q[wp_q] <= {rx_q[OSW_W-2:0], mi_s_q[1]};
        wp_q        <= ~wp_q;
      end
      if (RX_VALID && RX_READY) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, rx_push} - {1'b0, RX_VALID && RX_READY};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_READY <= 1'b0;
      RX_VALID <= 1'b0;
      RX_DATA  <= 8'h00;
      BUSY     <= 1'b0;
    end else begin
      // High only in the cycle that ends on a tick, so ready always means taken
      TX_READY <= (div_q == OSW_DIV_LAST - 4'h1) && ~rx_full && cnt_q == 2'h0 &&
                  (st_q == OSW_IDLE || (st_q == OSW_LOW && bit_q == OSW_ZERO3 &&
                   word_q + 3'h1 < CHAIN_LEN));
      RX_VALID <= (cnt_q != 2'h0) && !(RX_VALID && RX_READY && cnt_q == 2'h1);
      RX_DATA  <= (RX_VALID && RX_READY) ? buf_q[~rp_q] : buf_q[rp_q];
      BUSY     <= (st_q != OSW_IDLE);
    end
  end

  assign LINK.cs_n = cs_q;
  assign LINK.sclk = sck_q;
  assign LINK.mosi = tx_q[OSW_MSB];
endmodule

// ---- verification/osw_asserts.sv ----
// Checker on the link wires between the device end and the host end.
// Assumes one clock and the host's five-cycle serial half period.
`timescale 1ns/10ps
module osw_asserts (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [5:0] bits_q;
  // Counts rising clocks per frame; a frame must end on a word boundary
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bits_q <= 6'h00;
    end else if (cs_n) begin
      bits_q <= 6'h00;
    end else if ($rose(sclk)) begin
      bits_q <= bits_q + 6'h01;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  oe_released_a: assert property (cs_n [*8] |-> !miso_oe)
    else $error("serial output driven while deselected");
  oe_enabled_a: assert property ($fell(cs_n) |-> ##[1:5] miso_oe)
    else $error("serial output not driven after select");
  cs_edge_low_a: assert property ($changed(cs_n) |-> !sclk)
    else $error("select changed with serial clock high");
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("serial clock runs while deselected");
  miso_steady_a: assert property (miso_oe && $fell(sclk) |-> $stable(miso))
    else $error("serial output moved at sampling edge");
  mosi_steady_a: assert property ($fell(sclk) |-> $stable(mosi))
    else $error("serial input moved at sampling edge");
  word_count_a: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0 && bits_q != 6'h00)
    else $error("frame not a whole number of words");
  half_period_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("serial clock high phase wrong");
endmodule

// ---- verification/octal_switch_serial_control_tb_top.sv ----
// Testbench joining the device end and the host end through the link.
// Assumes the short fault delay is shortened to 20 cycles.
`timescale 1ns/10ps
module octal_switch_serial_control_tb_top;
  import osw_pkg::*;
  logic       clk, rst_n, sfld, tx_valid, tx_ready, rx_valid, rx_ready, busy;
  logic [2:0] chain_len;
  logic [7:0] tx_data, rx_data, out_off, short_fault, open_fault;
  int         miscompares, comparisons;
  osw_if link ();
  osw_dev #(.SF_DLY_CYC(20)) osw_dev_i (.CLK(clk), .RST_N(rst_n), .LINK(link),
    .SHORT_FAULT_LATCH_DISABLE(sfld), .SHORT_FAULT(short_fault),
    .OPEN_FAULT(open_fault), .OUT_OFF(out_off));
  osw_host osw_host_i (.CLK(clk), .RST_N(rst_n), .LINK(link), .CHAIN_LEN(chain_len),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_READY(rx_ready), .BUSY(busy));
  osw_asserts osw_asserts_i (.CLK(clk), .RST_N(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  always #20 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One frame; a stall holds the reader off to show the word is kept
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] st, input int stall);
    int n;
    @(posedge clk) tx_valid <= 1'b1;
    tx_data <= cmd;
    n = 0;
    // Request stands until the edge at which ready is seen high
    do begin
      @(posedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 400);
    tx_valid <= 1'b0;
    for (n = 0; n < 400 && rx_valid !== 1'b1; n++) @(negedge clk);
    repeat (stall) @(negedge clk);
    chk(rx_data, st);
    @(posedge clk) rx_ready <= 1'b1;
    @(posedge clk) rx_ready <= 1'b0;
    for (n = 0; n < 400 && (busy !== 1'b0 || link.cs_n !== 1'b1); n++) @(negedge clk);
    repeat (8) @(negedge clk);
    chk(out_off, cmd);
  endtask
  task automatic t_command;
    xfer(8'ha5, OSW_ALL_OFF, 0);
    xfer(8'h3c, 8'ha5, 30);
  endtask
  // Latch-off must hit only the shorted outputs that are commanded ON
  task automatic t_short;
    short_fault <= 8'h81;
    xfer(8'h00, 8'hbd, 0);
    repeat (40) @(negedge clk);
    chk(out_off, 8'h81);
    xfer(8'hff, 8'h81, 0);
    sfld <= 1'b1;
    xfer(8'h00, OSW_ALL_OFF, 0);
    repeat (40) @(negedge clk);
    chk(out_off, 8'h00);
    short_fault <= 8'h00;
    open_fault <= 8'h02;
    xfer(8'h0f, 8'h00, 0);
    xfer(8'hff, 8'h0d, 0);
    open_fault <= 8'h00;
  endtask
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    {clk, rst_n, sfld, tx_valid, rx_ready} = 5'h00;
    {tx_data, short_fault, open_fault} = 24'h000000;
    chain_len = 3'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk(out_off, OSW_ALL_OFF);
    t_command;
    t_short;
    test_done;
  end
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
endmodule
